// ==== serin_pkg.sv ====
package serin_pkg;

	// ----------------------------------------------------------------
	// clocking and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned HZ_PER_MHZ = 1_000_000;
	localparam int unsigned CYCLES_PER_US = CLK_HZ / HZ_PER_MHZ;
	localparam int unsigned MS_TICK_US = 1000;
	localparam int unsigned MS_TICK_CYCLES = MS_TICK_US * CYCLES_PER_US;
	localparam int unsigned LINE_PERIOD_OFFSET_US = 20;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_LINE = 8'h04;
	localparam logic [7:0] ADDR_TIMEOUT = 8'h08;
	localparam logic [7:0] ADDR_PREFIX = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_CAPT_BASE = 8'h40;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_PAR_BIT = 1;
	localparam int CTRL_TOTAL_LSB = 4;
	localparam int CTRL_FLOW_BIT = 8;
	localparam int CTRL_PREFIX_BIT = 9;
	localparam int CTRL_PLEN_LSB = 10;
	localparam int CTRL_SLEN_LSB = 16;
	localparam int LINE_PERIOD_MSB = 11;
	localparam int LINE_SEVEN_E_BIT = 13;
	localparam int LINE_INV_BIT = 14;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_PAR_BIT = 2;
	localparam int STAT_TMO_BIT = 3;
	localparam int STAT_COUNT_LSB = 8;

	// ----------------------------------------------------------------
	// character length settings and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] BITS_DEFAULT = 4'h8;
	localparam logic [3:0] BITS_MIN = 4'h4;
	localparam logic [3:0] BITS_MAX = 4'h8;
	localparam logic [3:0] BITS_MIN_PAR = 4'h5;
	localparam logic [3:0] BITS_MAX_PAR = 4'h9;
	localparam logic [3:0] BITS_SEVEN = 4'h7;
	localparam logic [3:0] BITS_BYTE = 4'h8;
	localparam logic [15:0] LINE_RESET = 16'h0054;

	typedef enum logic [2:0] {
		st_idle,
		st_wait,
		st_start,
		st_data,
		st_parity,
		st_stop
	} rx_state_type;

endpackage

// ==== capture_mem.sv ====
`timescale 1ns/10ps
module capture_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_wr_en,
	input wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
	input wire logic [WIDTH-1:0] i_wr_data,
	input wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
	output logic [WIDTH-1:0] o_rd_data
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] cells;
		logic [WIDTH-1:0] rdata;
	} mem_state_type;

	mem_state_type m_r;
	mem_state_type m_nxt;

	always_comb begin
		m_nxt = m_r;
		m_nxt.rdata = m_r.cells[i_rd_addr];
		if (i_wr_en) begin
			m_nxt.cells[i_wr_addr] = i_wr_data;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			m_r <= '0;
		end else begin
			m_r <= m_nxt;
		end
	end

	assign o_rd_data = m_r.rdata;
endmodule

// ==== serial_receiver.sv ====
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/10ps
// Contract
// - character length 4 to 8, default 8
// - parity bit counts within bit total
// - setting 9 with parity gives 8+parity
// - even parity only over data plus parity
// - recompute parity, flag mismatch as error
// - parity error aborts reception immediately
// - zero timeout waits forever for data
// - millisecond timeout aborts with timeout outcome
// - parity and timeout usable together, distinct
// - start: receive input, flow shows ready
// - after completion flow shows not-ready
// - flow levels follow line polarity
// - prefix filter discards until sequence matched
// - string capture stores from lowest index
// - length limit n stops after n chars
// - no buffer, idle characters are dropped
// - line word: period, seven-even, inversion bits
module serial_receiver #(
	parameter int DEPTH = 16,
	parameter int unsigned MS_TICK_CYCLES = serin_pkg::MS_TICK_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_rx,
	output logic o_flow,
	output logic o_flow_oe
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int MW = $clog2(MS_TICK_CYCLES + 1);
	localparam logic [7:0] CAPT_END = 8'(serin_pkg::ADDR_CAPT_BASE + 4 * DEPTH);

	typedef struct packed {
		logic rx_meta;
		logic rx_sync;
		serin_pkg::rx_state_type state;
		logic [15:0] line;
		logic [15:0] tmo_ms;
		logic [31:0] prefix;
		logic par_cfg;
		logic [3:0] total_cfg;
		logic flow_cfg;
		logic pre_cfg;
		logic [1:0] plen_cfg;
		logic [4:0] slen_cfg;
		logic busy;
		logic done;
		logic par_err;
		logic tmo_err;
		logic inv;
		logic par_on;
		logic [3:0] payload;
		logic [19:0] period;
		logic [19:0] tick;
		logic [3:0] bit_idx;
		logic [7:0] shreg;
		logic par_acc;
		logic [MW-1:0] ms_div;
		logic [15:0] ms_cnt;
		logic [2:0] matched;
		logic [CW-1:0] count;
		logic [CW-1:0] limit;
		logic flow_oe;
		logic flow_lvl;
		logic rd_ready;
		logic rd_mem;
		logic [31:0] rdata;
	} state_type;

	state_type s_r;
	state_type s_nxt;

	logic rx_bit;
	logic [7:0] char_v;
	logic [3:0] tot;
	logic [2:0] plen;
	logic mem_we;
	logic [7:0] mem_rdata;
	logic capt_hit;
	logic finish;

	// ----------------------------------------------------------------
	// receive state machine and register slave
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		mem_we = 1'b0;
		finish = 1'b0;
		tot = serin_pkg::BITS_DEFAULT;
		rx_bit = s_r.inv ? ~s_r.rx_sync : s_r.rx_sync;
		char_v = s_r.shreg >> (serin_pkg::BITS_BYTE - s_r.payload);
		plen = {1'b0, s_r.plen_cfg} + 3'h1;
		capt_hit = (i_avs_address >= serin_pkg::ADDR_CAPT_BASE) && (i_avs_address < CAPT_END);
		s_nxt.rx_meta = i_rx;
		s_nxt.rx_sync = s_r.rx_meta;
		if (s_r.tick != '0) begin
			s_nxt.tick = s_r.tick - 20'h1;
		end
		case (s_r.state)
			serin_pkg::st_wait: begin
				if (rx_bit == 1'b0) begin
					// half a period lands the next check at mid start bit
					s_nxt.tick = s_r.period >> 1;
					s_nxt.ms_div = '0;
					s_nxt.ms_cnt = '0;
					s_nxt.state = serin_pkg::st_start;
				end else if (s_r.tmo_ms != '0 && s_r.ms_cnt == s_r.tmo_ms) begin
					s_nxt.tmo_err = 1'b1;
					finish = 1'b1;
				end else if (s_r.ms_div == MW'(MS_TICK_CYCLES - 1)) begin
					s_nxt.ms_div = '0;
					if (s_r.tmo_ms != '0) begin
						s_nxt.ms_cnt = s_r.ms_cnt + 16'h1;
					end
				end else begin
					s_nxt.ms_div = s_r.ms_div + MW'(1);
				end
			end
			serin_pkg::st_start: begin
				if (s_r.tick == '0) begin
					if (rx_bit == 1'b0) begin
						s_nxt.tick = s_r.period - 20'h1;
						s_nxt.bit_idx = '0;
						s_nxt.par_acc = 1'b0;
						s_nxt.state = serin_pkg::st_data;
					end else begin
						// a glitch, not a start bit
						s_nxt.state = serin_pkg::st_wait;
					end
				end
			end
			serin_pkg::st_data: begin
				if (s_r.tick == '0) begin
					s_nxt.shreg = {rx_bit, s_r.shreg[7:1]};
					s_nxt.par_acc = s_r.par_acc ^ rx_bit;
					s_nxt.bit_idx = s_r.bit_idx + 4'h1;
					s_nxt.tick = s_r.period - 20'h1;
					if (s_r.bit_idx == s_r.payload - 4'h1) begin
						s_nxt.state = s_r.par_on ? serin_pkg::st_parity : serin_pkg::st_stop;
					end
				end
			end
			serin_pkg::st_parity: begin
				if (s_r.tick == '0) begin
					s_nxt.tick = s_r.period - 20'h1;
					if (rx_bit != s_r.par_acc) begin
						s_nxt.par_err = 1'b1;
						finish = 1'b1;
					end else begin
						s_nxt.state = serin_pkg::st_stop;
					end
				end
			end
			serin_pkg::st_stop: begin
				// stop level is not checked; the sample point only paces the frame
				if (s_r.tick == '0) begin
					s_nxt.state = serin_pkg::st_wait;
					s_nxt.ms_div = '0;
					s_nxt.ms_cnt = '0;
					if (s_r.pre_cfg && s_r.matched < plen) begin
						if (char_v == s_r.prefix[8 * s_r.matched[1:0] +: 8]) begin
							s_nxt.matched = s_r.matched + 3'h1;
						end else if (char_v == s_r.prefix[7:0]) begin
							s_nxt.matched = 3'h1;
						end else begin
							s_nxt.matched = '0;
						end
					end else begin
						mem_we = 1'b1;
						s_nxt.count = s_r.count + CW'(1);
						if (s_r.count + CW'(1) == s_r.limit) begin
							s_nxt.done = 1'b1;
							finish = 1'b1;
						end
					end
				end
			end
			default: begin
				s_nxt.state = serin_pkg::st_idle;
			end
		endcase
		if (finish) begin
			s_nxt.busy = 1'b0;
			s_nxt.state = serin_pkg::st_idle;
			s_nxt.flow_lvl = ~s_r.inv;
		end

		// read: one wait cycle, then registered data
		s_nxt.rd_ready = i_avs_read & ~s_r.rd_ready;
		if (i_avs_read && !s_r.rd_ready) begin
			s_nxt.rd_mem = 1'b0;
			s_nxt.rdata = '0;
			if (i_avs_address == serin_pkg::ADDR_CTRL) begin
				s_nxt.rdata[serin_pkg::CTRL_PAR_BIT] = s_r.par_cfg;
				s_nxt.rdata[serin_pkg::CTRL_TOTAL_LSB +: 4] = s_r.total_cfg;
				s_nxt.rdata[serin_pkg::CTRL_FLOW_BIT] = s_r.flow_cfg;
				s_nxt.rdata[serin_pkg::CTRL_PREFIX_BIT] = s_r.pre_cfg;
				s_nxt.rdata[serin_pkg::CTRL_PLEN_LSB +: 2] = s_r.plen_cfg;
				s_nxt.rdata[serin_pkg::CTRL_SLEN_LSB +: 5] = s_r.slen_cfg;
			end else if (i_avs_address == serin_pkg::ADDR_LINE) begin
				s_nxt.rdata[15:0] = s_r.line;
			end else if (i_avs_address == serin_pkg::ADDR_TIMEOUT) begin
				s_nxt.rdata[15:0] = s_r.tmo_ms;
			end else if (i_avs_address == serin_pkg::ADDR_PREFIX) begin
				s_nxt.rdata = s_r.prefix;
			end else if (i_avs_address == serin_pkg::ADDR_STATUS) begin
				s_nxt.rdata[serin_pkg::STAT_BUSY_BIT] = s_r.busy;
				s_nxt.rdata[serin_pkg::STAT_DONE_BIT] = s_r.done;
				s_nxt.rdata[serin_pkg::STAT_PAR_BIT] = s_r.par_err;
				s_nxt.rdata[serin_pkg::STAT_TMO_BIT] = s_r.tmo_err;
				s_nxt.rdata[serin_pkg::STAT_COUNT_LSB +: CW] = s_r.count;
			end else if (capt_hit) begin
				s_nxt.rd_mem = 1'b1;
			end
		end

		// configuration is frozen while a reception runs
		if (i_avs_write && !s_r.busy) begin
			if (i_avs_address == serin_pkg::ADDR_CTRL) begin
				if (i_avs_byteenable[0]) begin
					s_nxt.par_cfg = i_avs_writedata[serin_pkg::CTRL_PAR_BIT];
					s_nxt.total_cfg = i_avs_writedata[serin_pkg::CTRL_TOTAL_LSB +: 4];
				end
				if (i_avs_byteenable[1]) begin
					s_nxt.flow_cfg = i_avs_writedata[serin_pkg::CTRL_FLOW_BIT];
					s_nxt.pre_cfg = i_avs_writedata[serin_pkg::CTRL_PREFIX_BIT];
					s_nxt.plen_cfg = i_avs_writedata[serin_pkg::CTRL_PLEN_LSB +: 2];
				end
				if (i_avs_byteenable[2]) begin
					s_nxt.slen_cfg = i_avs_writedata[serin_pkg::CTRL_SLEN_LSB +: 5];
				end
			end else if (i_avs_address == serin_pkg::ADDR_LINE) begin
				if (i_avs_byteenable[0]) begin
					s_nxt.line[7:0] = i_avs_writedata[7:0];
				end
				if (i_avs_byteenable[1]) begin
					s_nxt.line[15:8] = i_avs_writedata[15:8];
				end
			end else if (i_avs_address == serin_pkg::ADDR_TIMEOUT) begin
				if (i_avs_byteenable[0]) begin
					s_nxt.tmo_ms[7:0] = i_avs_writedata[7:0];
				end
				if (i_avs_byteenable[1]) begin
					s_nxt.tmo_ms[15:8] = i_avs_writedata[15:8];
				end
			end else if (i_avs_address == serin_pkg::ADDR_PREFIX) begin
				for (int b = 0; b < 4; b++) begin
					if (i_avs_byteenable[b]) begin
						s_nxt.prefix[8 * b +: 8] = i_avs_writedata[8 * b +: 8];
					end
				end
			end
		end

		// start of a reception latches the frame format
		if (i_avs_write && !s_r.busy && i_avs_address == serin_pkg::ADDR_CTRL
				&& i_avs_byteenable[0] && i_avs_writedata[serin_pkg::CTRL_START_BIT]) begin
			if (s_nxt.total_cfg != '0) begin
				tot = s_nxt.total_cfg;
			end
			if (s_nxt.par_cfg) begin
				if (tot < serin_pkg::BITS_MIN_PAR || tot > serin_pkg::BITS_MAX_PAR) begin
					tot = serin_pkg::BITS_DEFAULT;
				end
			end else if (tot < serin_pkg::BITS_MIN || tot > serin_pkg::BITS_MAX) begin
				tot = serin_pkg::BITS_DEFAULT;
			end
			if (s_nxt.line[serin_pkg::LINE_SEVEN_E_BIT]) begin
				s_nxt.par_on = 1'b1;
				s_nxt.payload = serin_pkg::BITS_SEVEN;
			end else begin
				s_nxt.par_on = s_nxt.par_cfg;
				s_nxt.payload = tot - {3'h0, s_nxt.par_cfg};
			end
			s_nxt.inv = s_nxt.line[serin_pkg::LINE_INV_BIT];
			s_nxt.period = 20'((20'(s_nxt.line[serin_pkg::LINE_PERIOD_MSB:0])
				+ 20'(serin_pkg::LINE_PERIOD_OFFSET_US)) * 20'(serin_pkg::CYCLES_PER_US));
			if (s_nxt.slen_cfg == '0 || 32'(s_nxt.slen_cfg) > DEPTH) begin
				s_nxt.limit = CW'(DEPTH);
			end else begin
				s_nxt.limit = CW'(s_nxt.slen_cfg);
			end
			s_nxt.busy = 1'b1;
			s_nxt.done = 1'b0;
			s_nxt.par_err = 1'b0;
			s_nxt.tmo_err = 1'b0;
			s_nxt.count = '0;
			s_nxt.matched = '0;
			s_nxt.ms_div = '0;
			s_nxt.ms_cnt = '0;
			s_nxt.tick = '0;
			s_nxt.flow_oe = s_nxt.flow_cfg;
			s_nxt.flow_lvl = s_nxt.line[serin_pkg::LINE_INV_BIT];
			s_nxt.state = serin_pkg::st_wait;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_r <= '0;
			s_r.line <= serin_pkg::LINE_RESET;
			s_r.flow_lvl <= 1'b1;
			s_r.rx_meta <= 1'b1;
			s_r.rx_sync <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	capture_mem #(
		.WIDTH(8),
		.DEPTH(DEPTH)
	) u_capture_list (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_wr_en(mem_we),
		.i_wr_addr(s_r.count[AW-1:0]),
		.i_wr_data(char_v),
		.i_rd_addr(i_avs_address[AW+1:2]),
		.o_rd_data(mem_rdata)
	);

	assign o_avs_waitrequest = i_avs_read & ~s_r.rd_ready;
	assign o_avs_readdata = s_r.rd_mem ? {24'h0, mem_rdata} : s_r.rdata;
	assign o_flow = s_r.flow_lvl;
	assign o_flow_oe = s_r.flow_oe;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_reset_n);

	a_flow_ready_busy: assert property (s_r.busy |-> o_flow == s_r.inv)
		else $error("flow pin not at ready level during reception");
	a_flow_stop_after: assert property ($fell(s_r.busy) |-> o_flow == ~s_r.inv)
		else $error("flow pin not at stop level after reception");
	a_parity_abort: assert property ($rose(s_r.par_err) |-> !s_r.busy && !mem_we
		&& $past(s_r.state) == serin_pkg::st_parity)
		else $error("parity error did not abort reception");
	a_parity_check: assert property (s_r.state == serin_pkg::st_parity
		&& s_r.tick == '0 && rx_bit != s_r.par_acc |=> s_r.par_err)
		else $error("parity mismatch not flagged");
	a_no_timeout_zero: assert property (s_r.tmo_ms == '0 |-> !$rose(s_r.tmo_err))
		else $error("timeout raised with timeout disabled");
	a_timeout_fires: assert property (s_r.state == serin_pkg::st_wait && rx_bit
		&& s_r.tmo_ms != '0 && s_r.ms_cnt == s_r.tmo_ms |=> s_r.tmo_err && !s_r.busy)
		else $error("timeout not reported");
	a_one_outcome: assert property (!(s_r.par_err && s_r.tmo_err))
		else $error("two outcomes at once");
	a_store_order: assert property (mem_we |=> s_r.count == $past(s_r.count) + CW'(1))
		else $error("capture index did not advance by one");
	a_limit_kept: assert property (s_r.busy |-> s_r.count < s_r.limit)
		else $error("capture passed its length limit");
	a_no_idle_capture: assert property (!s_r.busy |-> !mem_we)
		else $error("character stored with no reception active");
	a_prefix_first: assert property (mem_we |-> !s_r.pre_cfg || s_r.matched == plen)
		else $error("capture began before prefix matched");
	a_payload_range: assert property (s_r.busy |-> s_r.payload >= serin_pkg::BITS_MIN
		&& s_r.payload <= serin_pkg::BITS_MAX)
		else $error("payload length out of range");

	c_done: cover property ($rose(s_r.done));
	c_parity: cover property ($rose(s_r.par_err));
	c_timeout: cover property ($rose(s_r.tmo_err));
	c_prefix: cover property (s_r.pre_cfg && mem_we);
endmodule

// ==== serial_sender_model.sv ====
`timescale 1ns/10ps
module serial_sender_model #(
	parameter int PERIOD = 800
) (
	input wire logic i_clock,
	input wire logic i_flow,
	input wire logic i_flow_oe,
	output logic o_line
);
	initial o_line = 1'b1;

	// ------------------------------------------------------------
	// line driving
	// ------------------------------------------------------------
	task automatic bit_out(input logic v, input logic inv);
		@(posedge i_clock);
		o_line <= v ^ inv;
		repeat (PERIOD - 1) @(posedge i_clock);
	endtask

	task automatic idle(input logic inv);
		@(posedge i_clock);
		o_line <= ~inv;
	endtask

	// par_bad flips the parity bit so a scenario can provoke an error
	task automatic send_char(input logic [7:0] data, input int nbits, input logic par_en,
			input logic par_bad, input logic inv, input logic use_flow);
		logic par;
		par = ^(data & ((8'h01 << nbits) - 8'h01)) ^ par_bad;
		// hold back between characters until the receiver shows ready
		while (use_flow && !(i_flow_oe === 1'b1 && i_flow === inv)) begin
			@(posedge i_clock);
		end
		bit_out(1'b0, inv);
		for (int i = 0; i < nbits; i++) begin
			bit_out(data[i], inv);
		end
		if (par_en) begin
			bit_out(par, inv);
		end
		bit_out(1'b1, inv);
	endtask
endmodule

// ==== async_serial_receiver_flow_bench.sv ====
`timescale 1ns/10ps
module async_serial_receiver_flow_bench;
	localparam int PERIOD = 800;
	logic i_clock, i_reset_n, i_avs_read, i_avs_write, o_avs_waitrequest, i_rx;
	logic o_flow, o_flow_oe;
	logic [7:0] i_avs_address;
	logic [31:0] i_avs_writedata, o_avs_readdata, rd;
	logic [3:0] i_avs_byteenable;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	int t0;
	logic [7:0] chars [4] = '{8'h51, 8'h58, 8'h59, 8'h5A};

	serial_receiver #(.DEPTH(16), .MS_TICK_CYCLES(40)) i_dut (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read),
		.i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable),
		.o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest),
		.i_rx(i_rx),
		.o_flow(o_flow),
		.o_flow_oe(o_flow_oe)
	);

	serial_sender_model #(.PERIOD(PERIOD)) i_sender (
		.i_clock(i_clock),
		.i_flow(o_flow),
		.i_flow_oe(o_flow_oe),
		.o_line(i_rx)
	);

	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end

	always @(posedge i_clock) cyc <= cyc + 1;

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one transfer; request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		int n;
		@(posedge i_clock);
		i_avs_address <= addr;
		i_avs_writedata <= data;
		i_avs_write <= wr;
		i_avs_read <= ~wr;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_avs_waitrequest !== 1'b0);
		rd = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
		// a write never waits, a read waits exactly one cycle
		check("bus wait states", n, wr ? 32'h1 : 32'h2);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			bus(1'b0, serin_pkg::ADDR_STATUS, 32'h0);
			n++;
		end while (rd[serin_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 30000);
	endtask

	task automatic check_capt(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, serin_pkg::ADDR_CAPT_BASE + 8'(idx * 4), 32'h0);
		check("capture byte", {24'h0, rd[7:0]}, {24'h0, exp});
	endtask

	task automatic report_and_stop();
		if (bad_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// budget sized from the five scenarios, about 85k cycles of line traffic
	initial begin
		repeat (98000) @(posedge i_clock);
		bad_count++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		i_reset_n = 1'b0;
		i_avs_address = 8'h00;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_writedata = 32'h0;
		i_avs_byteenable = 4'hF;
		repeat (5) @(posedge i_clock);
		i_reset_n <= 1'b1;
		check("flow after reset", {30'h0, o_flow_oe, o_flow}, 32'h1);
		bus(1'b0, serin_pkg::ADDR_LINE, 32'h0);
		check("line reset", rd, 32'h0000_0054);
		bus(1'b0, 8'h3C, 32'h0);
		check("unmapped read", rd, 32'h0);
		bus(1'b1, serin_pkg::ADDR_LINE, 32'h0);
		// a character while idle must leave no trace
		i_sender.send_char(8'h77, 8, 1'b0, 1'b0, 1'b0, 1'b0);
		bus(1'b1, serin_pkg::ADDR_CTRL, 32'h0002_0101);
		repeat (3) @(posedge i_clock);
		check("flow ready true", {30'h0, o_flow_oe, o_flow}, 32'h2);
		i_sender.send_char(8'h3C, 8, 1'b0, 1'b0, 1'b0, 1'b1);
		i_sender.send_char(8'hC5, 8, 1'b0, 1'b0, 1'b0, 1'b1);
		wait_idle();
		check("status limit", rd & 32'h1F0F, 32'h0202);
		check("flow stop true", {30'h0, o_flow_oe, o_flow}, 32'h3);
		check_capt(8'd0, 8'h3C);
		check_capt(8'd1, 8'hC5);

		// inverted line, nine-bit total with parity, bad parity second
		i_sender.idle(1'b1);
		bus(1'b1, serin_pkg::ADDR_LINE, 32'h0000_4000);
		bus(1'b1, serin_pkg::ADDR_CTRL, 32'h0002_0193);
		repeat (3) @(posedge i_clock);
		check("flow ready inv", {30'h0, o_flow_oe, o_flow}, 32'h3);
		i_sender.send_char(8'hA5, 8, 1'b1, 1'b0, 1'b1, 1'b1);
		i_sender.send_char(8'h5A, 8, 1'b1, 1'b1, 1'b1, 1'b1);
		wait_idle();
		check("status parity", rd & 32'h1F0D, 32'h0104);
		check_capt(8'd0, 8'hA5);

		// silent line with parity on and a 3 ms limit
		i_sender.idle(1'b0);
		bus(1'b1, serin_pkg::ADDR_LINE, 32'h0);
		bus(1'b1, serin_pkg::ADDR_TIMEOUT, 32'h3);
		bus(1'b1, serin_pkg::ADDR_CTRL, 32'h0001_0003);
		t0 = cyc;
		wait_idle();
		check("status timeout", rd & 32'h1F0D, 32'h0008);
		check("timeout span", {31'h0, (cyc - t0) inside {[112:136]}}, 32'h1);

		// prefix filter, no limit on waiting
		bus(1'b1, serin_pkg::ADDR_TIMEOUT, 32'h0);
		bus(1'b1, serin_pkg::ADDR_PREFIX, 32'h0000_5958);
		bus(1'b1, serin_pkg::ADDR_CTRL, 32'h0001_0601);
		repeat (3000) @(posedge i_clock);
		bus(1'b0, serin_pkg::ADDR_STATUS, 32'h0);
		check("status waiting", rd & 32'h000F, 32'h0001);
		foreach (chars[i]) i_sender.send_char(chars[i], 8, 1'b0, 1'b0, 1'b0, 1'b0);
		wait_idle();
		check("status prefix", rd & 32'h1F0F, 32'h0102);
		check_capt(8'd0, 8'h5A);

		// seven-bit even parity selected by the line word alone
		bus(1'b1, serin_pkg::ADDR_LINE, 32'h0000_2000);
		bus(1'b1, serin_pkg::ADDR_CTRL, 32'h0001_0001);
		i_sender.send_char(8'h1A, 7, 1'b1, 1'b0, 1'b0, 1'b0);
		wait_idle();
		check("status seven even", rd & 32'h1F0F, 32'h0102);
		check_capt(8'd0, 8'h1A);
		report_and_stop();
	end
endmodule
